// file: core/adc_ctrl_regs.vh
// Purpose: Constants for the converter conversion-control block
// Assumes: Byte-wide register port, one access per cycle
// Notes: Register indices are local selects on the documented port
//
// Contract
// - Any write to control one aborts, then in software trigger mode restarts unless channel is all ones.
// - Compare off: done flag bit 7 sets at every conversion end; a done that coincides with a control one write is dropped.
// - Compare on: done flag sets at conversion end only if compare true.
// - Done flag clears on control one write or result low read.
// - Interrupt asserts when done flag sets with enable bit 6 high.
// - Continuous bit 5 clear: one conversion per software or hardware trigger.
// - Continuous bit set: back to back conversions after first trigger.
// - Channel select field occupies bits 4 to 0 of control one.
// - Codes 0-27 analog inputs, 28 reserved, 29 high ref, 30 low ref.
// - All ones channel turns converter off and isolates input.
// - Ending continuous mode with all ones causes no extra conversion.
// - Single mode enters low power after each conversion completes.
// - Control two bit 6 selects software (0) or hardware (1) trigger.
// - Control two bit 7 shows conversion active, cleared on end or abort.
// - In 10-bit mode, high result read blocks transfers until low read.
`ifndef ADC_CTRL_REGS_VH
`define ADC_CTRL_REGS_VH

`define SEL_CTRL_ONE 3'h0
`define SEL_CTRL_TWO 3'h1
`define SEL_RES_HIGH 3'h2
`define SEL_RES_LOW 3'h3
`define SEL_CMP_HIGH 3'h4
`define SEL_CMP_LOW 3'h5
`define SEL_CFG 3'h6

`define BIT_DONE 7
`define BIT_IEN 6
`define BIT_CONT 5
`define BIT_ACTIVE 7
`define BIT_TRIG 6
`define BIT_CMPEN 5
`define BIT_CMPGT 4
`define CH_MSB 4
`define CH_OFF 5'h1F
`define CH_LAST_ANALOG 5'h1B
`define CH_RESERVED 5'h1C
`define CH_HIGH_REF 5'h1D
`define CH_LOW_REF 5'h1E
`define SRC_NONE 3'h0
`define SRC_ANALOG 3'h1
`define SRC_HIGH_REF 3'h2
`define SRC_LOW_REF 3'h3
`define SRC_RESERVED 3'h4

`define CTRL_ONE_RESET 8'h1F
`define CTRL_TWO_RESET 8'h00
`define CFG_MODE_LSB 2
`define CFG_MODE_10 2'h2
`define CONV_CYCLES 4'hB

`endif

// file: core/adc_sar_engine.v
// Purpose: Successive-approximation step engine, one bit per cycle
// Assumes: Comparator answer valid one cycle after trial is driven
// Notes: Abort returns to idle at once, unless start is high in the same cycle, which restarts

`timescale 1ns/1ps
`include "adc_ctrl_regs.vh"

module adc_sar_engine (
  input wire clk_i,
  input wire reset_n_i,
  input wire start_i,
  input wire abort_i,
  input wire cmp_high_i,
  output reg [9:0] trial_o,
  output reg busy_o,
  output reg done_o,
  output reg [9:0] result_o
);
  reg [3:0] step_reg;
  reg [9:0] bit_reg;

  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      step_reg <= 4'h0;
      bit_reg <= 10'h000;
      trial_o <= 10'h000;
      busy_o <= 1'b0;
      done_o <= 1'b0;
      result_o <= 10'h000;
    end else begin
      done_o <= 1'b0;
      if (abort_i) begin
        busy_o <= 1'b0;
        step_reg <= 4'h0;
      end
      if (start_i) begin
        busy_o <= 1'b1;
        step_reg <= 4'h1;
        bit_reg <= 10'h200;
        trial_o <= 10'h200;
      end else if (busy_o && !abort_i) begin
        // Keep bit if input above trial, then try next
        if (step_reg == `CONV_CYCLES - 4'h1) begin
          busy_o <= 1'b0;
          done_o <= 1'b1;
          result_o <= cmp_high_i ? trial_o : (trial_o & ~bit_reg);
          step_reg <= 4'h0;
        end else begin
          step_reg <= step_reg + 4'h1;
          bit_reg <= bit_reg >> 1;
          trial_o <= (cmp_high_i ? trial_o : (trial_o & ~bit_reg)) | (bit_reg >> 1);
        end
      end
    end
  end
endmodule

// file: core/adc_conversion_control.v
// Purpose: Status/control, trigger and result logic of a 10-bit converter
// Assumes: Register port strobes are one-cycle pulses, synchronous inputs
// Notes: Analog front end is outside; select and power go out as pins

`timescale 1ns/1ps
`include "adc_ctrl_regs.vh"

module adc_conversion_control (
  input wire clk_i,
  input wire reset_n_i,
  input wire [2:0] reg_sel_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [7:0] reg_wdata_i,
  input wire hardware_trigger_input_i,
  input wire comparator_high_i,
  output reg [7:0] reg_rdata_o,
  output reg done_irq_o,
  output wire [9:0] dac_trial_o,
  output reg [2:0] input_source_o,
  output reg [4:0] analog_index_o,
  output reg converter_power_o
);
  localparam ST_IDLE = 3'b001;
  localparam ST_CONV = 3'b010;
  localparam ST_OFF = 3'b100;

  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg conversion_done_flag_reg;
  reg done_interrupt_enable_reg;
  reg continuous_enable_reg;
  reg [4:0] channel_select_reg;
  reg trigger_select_reg;
  reg compare_enable_reg;
  reg compare_gt_reg;
  reg [7:0] cfg_reg;
  reg [1:0] cmp_high_reg;
  reg [7:0] cmp_low_reg;
  reg [1:0] result_high_reg;
  reg [7:0] result_low_reg;
  reg result_lock_reg;
  reg trig_prev_reg;

  wire eng_busy;
  wire eng_done;
  wire [9:0] eng_result;

  wire wr_one = reg_wr_i && (reg_sel_i == `SEL_CTRL_ONE);
  wire wr_two = reg_wr_i && (reg_sel_i == `SEL_CTRL_TWO);
  wire rd_high = reg_rd_i && (reg_sel_i == `SEL_RES_HIGH);
  wire rd_low = reg_rd_i && (reg_sel_i == `SEL_RES_LOW);
  wire new_off = (reg_wdata_i[`CH_MSB:0] == `CH_OFF);
  // Channel as it stands after this edge, so the input switches with the start
  wire [4:0] ch_now = wr_one ? reg_wdata_i[`CH_MSB:0] : channel_select_reg;
  wire hw_edge = hardware_trigger_input_i && !trig_prev_reg;
  wire mode_10 = (cfg_reg[`CFG_MODE_LSB+1:`CFG_MODE_LSB] == `CFG_MODE_10);
  wire [9:0] cmp_value = mode_10 ? {cmp_high_reg, cmp_low_reg} : {2'h0, cmp_low_reg};
  wire [9:0] res_cut = mode_10 ? eng_result : {2'h0, eng_result[9:2]};
  wire cmp_true = compare_gt_reg ? (res_cut >= cmp_value) : (res_cut < cmp_value);
  wire accept = eng_done && (!compare_enable_reg || cmp_true);
  wire active = (state_reg == ST_CONV);

  // Software start: write with non-off channel; hardware mode waits edge
  wire sw_start = wr_one && !new_off && !trigger_select_reg;
  wire hw_start = trigger_select_reg && hw_edge && channel_select_reg != `CH_OFF
                  && !active && !wr_one;
  wire cont_start = eng_done && continuous_enable_reg && !wr_one
                    && channel_select_reg != `CH_OFF;
  wire start = sw_start || hw_start || cont_start;

  function [2:0] source_of;
    input [4:0] ch;
    begin
      if (ch <= `CH_LAST_ANALOG)
        source_of = `SRC_ANALOG;
      else if (ch == `CH_HIGH_REF)
        source_of = `SRC_HIGH_REF;
      else if (ch == `CH_LOW_REF)
        source_of = `SRC_LOW_REF;
      else if (ch == `CH_RESERVED)
        source_of = `SRC_RESERVED;
      else
        source_of = `SRC_NONE;
    end
  endfunction

  adc_sar_engine u_engine (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .start_i(start),
    .abort_i(wr_one),
    .cmp_high_i(comparator_high_i),
    .trial_o(dac_trial_o),
    .busy_o(eng_busy),
    .done_o(eng_done),
    .result_o(eng_result)
  );

  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (start)
          state_next = ST_CONV;
        else if (channel_select_reg == `CH_OFF)
          state_next = ST_OFF;
      end
      ST_CONV: begin
        if (start)
          state_next = ST_CONV;
        else if (wr_one && new_off)
          state_next = ST_OFF;
        else if (wr_one || eng_done)
          state_next = ST_IDLE;
      end
      ST_OFF: begin
        if (start)
          state_next = ST_CONV;
        else if (channel_select_reg != `CH_OFF)
          state_next = ST_IDLE;
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_reg <= ST_OFF;
      conversion_done_flag_reg <= 1'b0;
      done_interrupt_enable_reg <= 1'b0;
      continuous_enable_reg <= 1'b0;
      channel_select_reg <= `CH_OFF;
      trigger_select_reg <= 1'b0;
      compare_enable_reg <= 1'b0;
      compare_gt_reg <= 1'b0;
      cfg_reg <= 8'h00;
      cmp_high_reg <= 2'h0;
      cmp_low_reg <= 8'h00;
      result_high_reg <= 2'h0;
      result_low_reg <= 8'h00;
      result_lock_reg <= 1'b0;
      trig_prev_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      trig_prev_reg <= hardware_trigger_input_i;
      if (wr_one) begin
        done_interrupt_enable_reg <= reg_wdata_i[`BIT_IEN];
        continuous_enable_reg <= reg_wdata_i[`BIT_CONT];
        channel_select_reg <= reg_wdata_i[`CH_MSB:0];
      end
      if (wr_two) begin
        trigger_select_reg <= reg_wdata_i[`BIT_TRIG];
        compare_enable_reg <= reg_wdata_i[`BIT_CMPEN];
        compare_gt_reg <= reg_wdata_i[`BIT_CMPGT];
      end
      if (reg_wr_i && reg_sel_i == `SEL_CFG)
        cfg_reg <= reg_wdata_i;
      if (reg_wr_i && reg_sel_i == `SEL_CMP_HIGH)
        cmp_high_reg <= reg_wdata_i[1:0];
      if (reg_wr_i && reg_sel_i == `SEL_CMP_LOW)
        cmp_low_reg <= reg_wdata_i;
      // Set wins over a result low read clear; a done that coincides with a control one write is dropped
      if (accept && !wr_one)
        conversion_done_flag_reg <= 1'b1;
      else if (wr_one || rd_low)
        conversion_done_flag_reg <= 1'b0;
      if (rd_high && mode_10)
        result_lock_reg <= 1'b1;
      else if (rd_low)
        result_lock_reg <= 1'b0;
      if (accept && !wr_one && !(result_lock_reg && mode_10)) begin
        result_high_reg <= mode_10 ? eng_result[9:8] : 2'h0;
        result_low_reg <= res_cut[7:0];
      end
    end
  end

  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      reg_rdata_o <= 8'h00;
      done_irq_o <= 1'b0;
      input_source_o <= `SRC_NONE;
      analog_index_o <= 5'h00;
      converter_power_o <= 1'b0;
    end else begin
      // Reads carry no side effect here
      case (reg_sel_i)
        `SEL_CTRL_ONE: reg_rdata_o <= {conversion_done_flag_reg, done_interrupt_enable_reg,
                                     continuous_enable_reg, channel_select_reg};
        `SEL_CTRL_TWO: reg_rdata_o <= {active, trigger_select_reg, compare_enable_reg,
                                     compare_gt_reg, 4'h0};
        `SEL_RES_HIGH: reg_rdata_o <= {6'h00, result_high_reg};
        `SEL_RES_LOW: reg_rdata_o <= result_low_reg;
        `SEL_CMP_HIGH: reg_rdata_o <= {6'h00, cmp_high_reg};
        `SEL_CMP_LOW: reg_rdata_o <= cmp_low_reg;
        `SEL_CFG: reg_rdata_o <= cfg_reg;
        default: reg_rdata_o <= 8'h00;
      endcase
      done_irq_o <= conversion_done_flag_reg && done_interrupt_enable_reg;
      input_source_o <= source_of(ch_now);
      analog_index_o <= (ch_now <= `CH_LAST_ANALOG) ? ch_now : 5'h00;
      converter_power_o <= active && eng_busy;
    end
  end
endmodule

// file: tb/adc_ctrl_assertions.sv
// Purpose: Port checks of the conversion control block
// Assumes: Register strobes are one-cycle pulses
// Notes: Bound to the conversion control module by the bind below
`timescale 1ns/1ps
module adc_ctrl_checker (
  input wire clk_i,
  input wire reset_n_i,
  input wire [2:0] reg_sel_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [7:0] reg_wdata_i,
  input wire [7:0] reg_rdata_o,
  input wire done_irq_o,
  input wire [2:0] input_source_o,
  input wire [4:0] analog_index_o,
  input wire converter_power_o
);
  logic trig_q;
  logic ien_q;
  logic cont_q;
  wire w1 = reg_wr_i && reg_sel_i == 3'h0;
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      trig_q <= 1'h0;
      ien_q <= 1'h0;
      cont_q <= 1'h0;
    end else if (w1) begin
      ien_q <= reg_wdata_i[6];
      cont_q <= reg_wdata_i[5];
    end else if (reg_wr_i && reg_sel_i == 3'h1) begin
      trig_q <= reg_wdata_i[6];
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_start; w1 && reg_wdata_i[4:0] != 5'h1F && !trig_q; endsequence
  sequence s_rise; $rose(converter_power_o); endsequence
  property p_start; s_start |-> ##[1:2] converter_power_o; endproperty
  a_start: assert property (p_start) else $error("no start on write");
  property p_off;
    (w1 && reg_wdata_i[4:0] == 5'h1F) ##1 (!w1) [*3]
      |-> (!$past(converter_power_o) && $past(input_source_o) == 3'h0)
      ##0 (!converter_power_o && input_source_o == 3'h0) [*2];
  endproperty
  a_off: assert property (p_off) else $error("converter not off");
  property p_decode;
    s_start and (reg_wdata_i[4:0] <= 5'h1B)
      |-> ##1 input_source_o == 3'h1 && analog_index_o == $past(reg_wdata_i[4:0]);
  endproperty
  a_decode: assert property (p_decode) else $error("wrong input");
  property p_irq_off; !ien_q && !$past(ien_q) |-> !done_irq_o; endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq while disabled");
  property p_wr_clear; w1 |-> ##2 !done_irq_o; endproperty
  a_wr_clear: assert property (p_wr_clear) else $error("flag kept after write");
  property p_single; s_rise ##0 !cont_q |-> ##[9:16] !converter_power_o; endproperty
  a_single: assert property (p_single) else $error("single did not stop");
  property p_cont; s_rise ##0 cont_q |-> (converter_power_o || reg_wr_i) [*8]; endproperty
  a_cont: assert property (p_cont) else $error("continuous stopped");
  property p_active;
    reg_rd_i && reg_sel_i == 3'h1 && !reg_wr_i && converter_power_o && $past(converter_power_o)
      |=> reg_rdata_o[7];
  endproperty
  a_active: assert property (p_active) else $error("active bit low");
endmodule
bind adc_conversion_control adc_ctrl_checker CHK (.clk_i(clk_i), .reset_n_i(reset_n_i),
  .reg_sel_i(reg_sel_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
  .reg_rdata_o(reg_rdata_o), .done_irq_o(done_irq_o), .input_source_o(input_source_o),
  .analog_index_o(analog_index_o), .converter_power_o(converter_power_o));

// file: tb/adc_far_side.sv
// Purpose: Analog comparator and trigger source model
// Assumes: Trial code settles before the next edge
// Notes: Comparator toggles while no input is selected
`timescale 1ns/1ps
module adc_far_side (
  input wire clk_i,
  input wire [9:0] level_i,
  input wire [9:0] trial_i,
  input wire [2:0] source_i,
  input wire fire_i,
  output logic cmp_o,
  output logic trig_o
);
  logic toggle = 1'h0;
  logic [9:0] v;
  always @(posedge clk_i) begin
    toggle <= !toggle;
    trig_o <= fire_i;
  end
  always @* begin
    v = source_i == 3'h2 ? 10'h3FF : (source_i == 3'h1 ? level_i : 10'h000);
    cmp_o = source_i == 3'h0 ? toggle : v >= trial_i;
  end
endmodule

// file: tb/adc_conversion_control_bench.sv
// Purpose: Self-checking bench of the conversion control block
// Assumes: 10-bit mode, inputs driven 1 ns after the edge
// Notes: Expected results come from the level fed to the comparator
`timescale 1ns/1ps
module adc_conversion_control_bench;
  logic clk_i = 1'h0;
  logic reset_n_i = 1'h0;
  logic reg_wr_i = 1'h0;
  logic reg_rd_i = 1'h0;
  logic fire = 1'h0;
  logic [2:0] reg_sel_i = 3'h0;
  logic [7:0] reg_wdata_i = 8'h00;
  logic [7:0] rd;
  logic [9:0] level = 10'h000;
  logic [9:0] old;
  logic [4:0] chs [5] = '{5'h00, 5'h1B, 5'h1D, 5'h1E, 5'h01};
  wire [7:0] reg_rdata_o;
  wire done_irq_o, cmp, hw, converter_power_o;
  wire [9:0] dac_trial_o;
  wire [2:0] input_source_o;
  wire [4:0] analog_index_o;
  int fails = 0;
  int n_tests = 0;
  always #50 clk_i = !clk_i;
  adc_conversion_control DUT (.clk_i(clk_i), .reset_n_i(reset_n_i), .reg_sel_i(reg_sel_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
    .hardware_trigger_input_i(hw), .comparator_high_i(cmp), .reg_rdata_o(reg_rdata_o),
    .done_irq_o(done_irq_o), .dac_trial_o(dac_trial_o), .input_source_o(input_source_o),
    .analog_index_o(analog_index_o), .converter_power_o(converter_power_o));
  adc_far_side FAR (.clk_i(clk_i), .level_i(level), .trial_i(dac_trial_o),
    .source_i(input_source_o), .fire_i(fire), .cmp_o(cmp), .trig_o(hw));
  task automatic chk(input string nm, input logic [9:0] s, input logic [9:0] e);
    n_tests++;
    if (s !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [2:0] s, input logic [7:0] d);
    @(posedge clk_i);
    #1 reg_sel_i = s;
    reg_wdata_i = d;
    reg_wr_i = 1'h1;
    @(posedge clk_i);
    #1 reg_wr_i = 1'h0;
  endtask
  task automatic rdr(input logic [2:0] s);
    @(posedge clk_i);
    #1 reg_sel_i = s;
    reg_rd_i = 1'h1;
    @(posedge clk_i);
    #1 reg_rd_i = 1'h0;
    rd = reg_rdata_o;
  endtask
  task automatic conv(input logic [4:0] ch, input logic ien, input logic flag);
    logic [9:0] e;
    e = ch <= 5'h1B ? level : (ch == 5'h1D ? 10'h3FF : 10'h000);
    wr(3'h0, {1'h0, ien, 1'h0, ch});
    rdr(3'h1);
    chk("active", rd[7], 1'h1);
    chk("source", input_source_o, ch <= 5'h1B ? 3'h1 : (ch == 5'h1D ? 3'h2 : 3'h3));
    chk("index", analog_index_o, ch <= 5'h1B ? ch : 5'h00);
    repeat (14) @(posedge clk_i);
    #1 chk("irq", done_irq_o, ien & flag);
    repeat (2) begin
      rdr(3'h0);
      chk("ctrl", rd, {flag, ien, 1'h0, ch});
    end
    if (flag) begin
      rdr(3'h2);
      chk("high", rd, {6'h00, e[9:8]});
      rdr(3'h3);
      chk("low", rd, e[7:0]);
      @(posedge clk_i);
      #1 chk("irqclr", done_irq_o, 1'h0);
    end
  endtask
  task automatic complete_run;
    $display("Comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    #1000000;
    fails++;
    complete_run();
  end
  initial begin
    void'($urandom(30));
    repeat (3) @(posedge clk_i);
    #1 reset_n_i = 1'h1;
    rdr(3'h0);
    chk("rst1", rd, 8'h1F);
    rdr(3'h1);
    chk("rst2", rd, 8'h00);
    wr(3'h6, 8'h08);
    chs[4] = 5'($urandom % 27);
    foreach (chs[i]) begin
      level = 10'($urandom);
      if (i == 1)
        wr(3'h0, 8'h1D);
      conv(chs[i], i[0], 1'h1);
    end
    wr(3'h4, 8'h03);
    wr(3'h5, 8'hFF);
    wr(3'h1, 8'h30);
    conv(5'h1D, 1'h1, 1'h1);
    conv(5'h1E, 1'h1, 1'h0);
    wr(3'h1, 8'h00);
    conv(5'h03, 1'h0, 1'h1);
    rdr(3'h2);
    old = level;
    level = ~level;
    wr(3'h0, 8'h03);
    repeat (14) @(posedge clk_i);
    rdr(3'h3);
    chk("locked", rd, old[7:0]);
    wr(3'h0, 8'h1C);
    #1 chk("reserved", input_source_o, 3'h4);
    repeat (14) @(posedge clk_i);
    wr(3'h0, 8'h25);
    repeat (40) @(posedge clk_i);
    #1 chk("cont", converter_power_o, 1'h1);
    wr(3'h0, 8'h3F);
    repeat (16) @(posedge clk_i);
    #1 chk("off", input_source_o, 3'h0);
    rdr(3'h0);
    chk("noextra", rd, 8'h3F);
    wr(3'h1, 8'h40);
    wr(3'h0, 8'h07);
    repeat (16) @(posedge clk_i);
    #1 chk("hwwait", converter_power_o, 1'h0);
    fire = 1'h1;
    @(posedge clk_i);
    #1 fire = 1'h0;
    repeat (16) @(posedge clk_i);
    #1 chk("lowpower", converter_power_o, 1'h0);
    rdr(3'h0);
    chk("hwdone", rd, 8'h87);
    rdr(3'h1);
    chk("idle", rd, 8'h40);
    complete_run();
  end
endmodule
